/* File: verilog/rls_consts.svh */
`ifndef RLS_CONSTS_SVH
`define RLS_CONSTS_SVH

// ----------------------------------------------------------------
// table geometry
// ----------------------------------------------------------------
`define RLS_ROWS 6
`define RLS_ROW_LEN 14
`define RLS_TBL_BYTES 84
`define RLS_CNT_W 8
`define RLS_IDX_W 7

// ----------------------------------------------------------------
// column positions inside a row
// ----------------------------------------------------------------
`define RLS_COL_FREQ 0
`define RLS_COL_CODE 1
`define RLS_COL_FIRST 2
`define RLS_GROUPS 6

// ----------------------------------------------------------------
// latency codes and reset values
// ----------------------------------------------------------------
`define RLS_LC_50 2'h3
`define RLS_LC_80 2'h0
`define RLS_LC_90 2'h1
`define RLS_LC_104 2'h2
`define RLS_LC_RESET 2'h3

// ----------------------------------------------------------------
// markers and command codes
// ----------------------------------------------------------------
`define RLS_UNSUP 8'hFF
`define RLS_NONE 8'h00
`define RLS_OP_QIO3 8'hEB
`define RLS_OP_QOUT3 8'h6B

`endif

/* File: verilog/rls_pkg.sv */
`include "rls_consts.svh"

package rls_pkg;

    typedef enum logic [1:0] {
        RLS_D_IDLE = 2'h0,
        RLS_D_MODE = 2'h1,
        RLS_D_DUMMY = 2'h2
    } rls_dev_st_t;

    typedef enum logic [2:0] {
        RLS_H_IDLE = 3'h0,
        RLS_H_ASK = 3'h1,
        RLS_H_GO = 3'h2,
        RLS_H_MODE = 3'h3,
        RLS_H_DUMMY = 3'h4,
        RLS_H_CHECK = 3'h5
    } rls_host_st_t;

    typedef logic [`RLS_CNT_W-1:0] rls_byte_t;

    typedef struct packed {
        rls_dev_st_t st;
        logic [1:0] code;
        logic hi_band;
        rls_byte_t cnt;
        rls_byte_t dummy;
        logic ack;
        rls_byte_t ack_mode;
        rls_byte_t ack_dummy;
        logic data_first;
        logic illegal;
        logic busy;
        rls_byte_t tbl_data;
    } rls_dev_state_t;

    typedef struct packed {
        rls_host_st_t st;
        rls_byte_t op;
        rls_byte_t cnt;
        rls_byte_t dummy;
        logic req;
        logic go;
        logic ready;
        logic mode_ph;
        logic dummy_ph;
        logic done;
        logic fail;
        logic reject;
    } rls_host_state_t;

endpackage : rls_pkg

/* File: verilog/rls_link_if.sv */
`timescale 1ns/1ps

interface rls_link_if;
    import rls_pkg::*;

    logic req;
    rls_byte_t op;
    logic go;
    logic ack;
    rls_byte_t mode;
    rls_byte_t dummy;
    logic data_first;

    modport dev (
        input req,
        input op,
        input go,
        output ack,
        output mode,
        output dummy,
        output data_first
    );

    modport host (
        output req,
        output op,
        output go,
        input ack,
        input mode,
        input dummy,
        input data_first
    );
endinterface : rls_link_if

/* File: verilog/rls_dev.sv */
// Overview of operation
// [RQ1] 50 MHz code 11b: read, fast zero cycles
// [RQ2] code 11b: quad-out none, quad-io 2+1
// [RQ3] 80 MHz code 00b: normal read unsupported
// [RQ4] code 00b: fast, quad-out eight dummy
// [RQ5] code 00b: quad-io two mode, four dummy
// [RQ6] 90 MHz code 01b: 8 dummy, quad-io 2+4
// [RQ7] 104 MHz code 10b: 8 dummy, quad-io 2+5
// [RQ8] 133 MHz band: only fast read, 0+8
// [RQ9] dual reads always marked unsupported
// [RQ10] host never issues an unsupported read
// [RQ11] fast read never has mode cycles
// [RQ12] quad-out read never has mode cycles
// [RQ13] table six rows of fourteen bytes
// [RQ14] quad-io uses EBh, quad-out uses 6Bh
// [RQ15] counts follow configured code, not clock
`timescale 1ns/1ps
`include "rls_consts.svh"

module rls_dev #(
    parameter int ROWS = `RLS_ROWS,
    parameter int ROW_LEN = `RLS_ROW_LEN
) (
    input wire logic CLK,
    input wire logic RST_N,
    rls_link_if.dev LNK,
    input wire logic CFG_WE,
    input wire logic [1:0] CFG_CODE,
    input wire logic CFG_HI_BAND,
    input wire logic [`RLS_IDX_W-1:0] TBL_INDEX,
    output logic [7:0] TBL_DATA,
    output logic [1:0] CUR_CODE,
    output logic BUSY,
    output logic ILLEGAL
);
    import rls_pkg::*;

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (ROWS != `RLS_ROWS || ROW_LEN != `RLS_ROW_LEN) begin : g_bad_geom
        $error("rls_dev: table geometry is fixed by its contents");
    end

    // ----------------------------------------------------------------
    // read_latency_table
    // ----------------------------------------------------------------
    // [RQ13] six rows by fourteen bytes
    localparam logic [7:0] TBL [0:`RLS_TBL_BYTES-1] = '{
        // header: column titles and opcodes, 3- then 4-byte address
        8'h46, 8'h43, 8'h03, 8'h13, 8'h0B, 8'h0C, 8'hFF,
        8'hFF, 8'h6B, 8'h6C, 8'hFF, 8'hFF, 8'hEB, 8'hEC,
        // 50 MHz, code 11b
        8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
        8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h02, 8'h01,
        // 80 MHz, code 00b
        8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
        8'hFF, 8'h00, 8'h08, 8'hFF, 8'hFF, 8'h02, 8'h04,
        // 90 MHz, code 01b
        8'h5A, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
        8'hFF, 8'h00, 8'h08, 8'hFF, 8'hFF, 8'h02, 8'h04,
        // 104 MHz, code 10b
        8'h68, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
        8'hFF, 8'h00, 8'h08, 8'hFF, 8'hFF, 8'h02, 8'h05,
        // 133 MHz, code 10b
        8'h85, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF
    };

    rls_dev_state_t q;
    rls_dev_state_t s;

    // ----------------------------------------------------------------
    // row selection and opcode lookup
    // ----------------------------------------------------------------
    int row;
    int base;
    logic hit;
    rls_byte_t lk_mode;
    rls_byte_t lk_dummy;
    logic lk_ok;

    always_comb begin
        row = 1;
        // [RQ15] row from configured code
        case (q.code)
            // [RQ1] 50 MHz band
            `RLS_LC_50: row = 1;
            // [RQ3] 80 MHz band
            `RLS_LC_80: row = 2;
            // [RQ6] 90 MHz band
            `RLS_LC_90: row = 3;
            // [RQ8] 133 MHz shares code 10b
            `RLS_LC_104: row = q.hi_band ? 5 : 4;
            default: row = 1;
        endcase
        base = row * ROW_LEN;
        hit = 1'b0;
        lk_mode = `RLS_UNSUP;
        lk_dummy = `RLS_UNSUP;
        // [RQ14] opcode match against header
        for (int g = 0; g < `RLS_GROUPS; g++) begin
            // [RQ9] unsupported opcodes never match
            if (LNK.op != `RLS_UNSUP &&
                (LNK.op == TBL[`RLS_COL_FIRST + 2 * g] ||
                 LNK.op == TBL[`RLS_COL_FIRST + 2 * g + 1])) begin
                hit = 1'b1;
                lk_mode = TBL[base + `RLS_COL_FIRST + 2 * g];
                lk_dummy = TBL[base + `RLS_COL_FIRST + 2 * g + 1];
            end
        end
        lk_ok = hit && lk_mode != `RLS_UNSUP && lk_dummy != `RLS_UNSUP;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s = q;
        s.ack = 1'b0;
        s.data_first = 1'b0;
        s.illegal = 1'b0;
        if (CFG_WE) begin
            s.code = CFG_CODE;
            s.hi_band = CFG_HI_BAND;
        end
        if (int'(TBL_INDEX) < `RLS_TBL_BYTES) begin
            s.tbl_data = TBL[TBL_INDEX];
        end else begin
            s.tbl_data = `RLS_NONE;
        end
        if (LNK.req) begin
            s.ack = 1'b1;
            s.ack_mode = lk_ok ? lk_mode : `RLS_UNSUP;
            s.ack_dummy = lk_ok ? lk_dummy : `RLS_UNSUP;
        end
        case (q.st)
            RLS_D_IDLE: begin
                if (LNK.go) begin
                    if (!lk_ok) begin
                        // [RQ10] unsupported go raises ILLEGAL and starts no read
                        s.illegal = 1'b1;
                    end else if (lk_mode != `RLS_NONE) begin
                        // [RQ2] mode cycles first
                        s.st = RLS_D_MODE;
                        s.cnt = lk_mode;
                        s.dummy = lk_dummy;
                    end else if (lk_dummy != `RLS_NONE) begin
                        // [RQ11] [RQ12] straight to dummy
                        s.st = RLS_D_DUMMY;
                        s.cnt = lk_dummy;
                    end else begin
                        s.data_first = 1'b1;
                    end
                end
            end
            RLS_D_MODE: begin
                s.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    // [RQ5] dummy after mode
                    if (q.dummy != `RLS_NONE) begin
                        s.st = RLS_D_DUMMY;
                        s.cnt = q.dummy;
                    end else begin
                        s.st = RLS_D_IDLE;
                        s.data_first = 1'b1;
                    end
                end
            end
            RLS_D_DUMMY: begin
                s.cnt = q.cnt - 8'h01;
                // [RQ4] [RQ7] data after last dummy
                if (q.cnt == 8'h01) begin
                    s.st = RLS_D_IDLE;
                    s.data_first = 1'b1;
                end
            end
            default: begin
                s.st = RLS_D_IDLE;
            end
        endcase
        s.busy = s.st != RLS_D_IDLE;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '{
                st: RLS_D_IDLE,
                code: `RLS_LC_RESET,
                hi_band: 1'b0,
                cnt: `RLS_NONE,
                dummy: `RLS_NONE,
                ack: 1'b0,
                ack_mode: `RLS_NONE,
                ack_dummy: `RLS_NONE,
                data_first: 1'b0,
                illegal: 1'b0,
                busy: 1'b0,
                tbl_data: `RLS_NONE
            };
        end else begin
            q <= s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign LNK.ack = q.ack;
    assign LNK.mode = q.ack_mode;
    assign LNK.dummy = q.ack_dummy;
    assign LNK.data_first = q.data_first;
    assign TBL_DATA = q.tbl_data;
    assign CUR_CODE = q.code;
    assign BUSY = q.busy;
    assign ILLEGAL = q.illegal;

endmodule : rls_dev

/* File: verilog/rls_host.sv */
`timescale 1ns/1ps
`include "rls_consts.svh"

module rls_host #(
    parameter int CNT_W = `RLS_CNT_W
) (
    input wire logic CLK,
    input wire logic RST_N,
    rls_link_if.host LNK,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_OP,
    output logic CMD_READY,
    output logic MODE_PH,
    output logic DUMMY_PH,
    output logic DONE,
    output logic FAIL,
    output logic REJECT
);
    import rls_pkg::*;

    if (CNT_W != `RLS_CNT_W) begin : g_bad_w
        $error("rls_host: counts are byte wide");
    end

    rls_host_state_t q;
    rls_host_state_t s;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s = q;
        s.req = 1'b0;
        s.go = 1'b0;
        s.done = 1'b0;
        s.fail = 1'b0;
        s.reject = 1'b0;
        case (q.st)
            RLS_H_IDLE: begin
                if (CMD_VALID) begin
                    s.op = CMD_OP;
                    s.req = 1'b1;
                    s.st = RLS_H_ASK;
                end
            end
            RLS_H_ASK: begin
                if (LNK.ack) begin
                    // [RQ10] never issue an unsupported read
                    if (LNK.mode == `RLS_UNSUP || LNK.dummy == `RLS_UNSUP) begin
                        s.reject = 1'b1;
                        s.st = RLS_H_IDLE;
                    end else begin
                        s.go = 1'b1;
                        s.cnt = LNK.mode;
                        s.dummy = LNK.dummy;
                        s.st = RLS_H_GO;
                    end
                end
            end
            RLS_H_GO: begin
                // [RQ2] insert matching mode cycles
                if (q.cnt != `RLS_NONE) begin
                    s.st = RLS_H_MODE;
                end else if (q.dummy != `RLS_NONE) begin
                    s.st = RLS_H_DUMMY;
                    s.cnt = q.dummy;
                end else begin
                    s.st = RLS_H_CHECK;
                end
            end
            RLS_H_MODE: begin
                s.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    if (q.dummy != `RLS_NONE) begin
                        s.st = RLS_H_DUMMY;
                        s.cnt = q.dummy;
                    end else begin
                        s.st = RLS_H_CHECK;
                    end
                end
            end
            RLS_H_DUMMY: begin
                // [RQ4] insert matching dummy cycles
                s.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    s.st = RLS_H_CHECK;
                end
            end
            RLS_H_CHECK: begin
                s.done = LNK.data_first;
                s.fail = !LNK.data_first;
                s.st = RLS_H_IDLE;
            end
            default: begin
                s.st = RLS_H_IDLE;
            end
        endcase
        s.ready = s.st == RLS_H_IDLE;
        s.mode_ph = s.st == RLS_H_MODE;
        s.dummy_ph = s.st == RLS_H_DUMMY;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '{
                st: RLS_H_IDLE,
                op: `RLS_NONE,
                cnt: `RLS_NONE,
                dummy: `RLS_NONE,
                req: 1'b0,
                go: 1'b0,
                ready: 1'b1,
                mode_ph: 1'b0,
                dummy_ph: 1'b0,
                done: 1'b0,
                fail: 1'b0,
                reject: 1'b0
            };
        end else begin
            q <= s;
        end
    end

    assign LNK.req = q.req;
    assign LNK.go = q.go;
    assign LNK.op = q.op;
    assign CMD_READY = q.ready;
    assign MODE_PH = q.mode_ph;
    assign DUMMY_PH = q.dummy_ph;
    assign DONE = q.done;
    assign FAIL = q.fail;
    assign REJECT = q.reject;

endmodule : rls_host

/* File: verif/rls_monitor.sv */
`timescale 1ns/1ps

module rls_monitor (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic req,
    input wire rls_pkg::rls_byte_t op,
    input wire logic go,
    input wire logic ack,
    input wire rls_pkg::rls_byte_t mode,
    input wire rls_pkg::rls_byte_t dummy,
    input wire logic data_first
);
    import rls_pkg::*;

    // ----------------------------------------------------------------
    // cycles since the read was started
    // ----------------------------------------------------------------
    logic run_r;
    logic [8:0] cnt_r;
    logic [8:0] want;
    logic unsup;
    logic known;

    assign want = {1'b0, mode} + {1'b0, dummy} + 9'h001;
    assign unsup = (mode == 8'hFF) && (dummy == 8'hFF);
    assign known = op inside {8'h03, 8'h13, 8'h0B, 8'h0C, 8'h6B, 8'h6C, 8'hEB, 8'hEC};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_r <= 1'b0;
            cnt_r <= 9'h000;
        end else begin
            run_r <= go ? 1'b1 : (data_first ? 1'b0 : run_r);
            cnt_r <= go ? 9'h001 : cnt_r + 9'h001;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence answer_s;
        ack ##1 !ack;
    endsequence

    req_answer_a:
        assert property (req |=> answer_s) else $error("ack missing after req");
    hold_counts_a:
        assert property (!ack |-> $stable(mode) && $stable(dummy))
        else $error("counts changed without ack");
    read_counts_a:
        assert property (ack && op inside {8'h03, 8'h13} |-> unsup || (mode == 8'h00
            && dummy == 8'h00)) else $error("normal read counts wrong");
    fast_no_mode_a:
        assert property (ack && op inside {8'h0B, 8'h0C} |-> mode == 8'h00
            && dummy inside {8'h00, 8'h08}) else $error("fast read counts wrong");
    quad_no_mode_a:
        assert property (ack && op inside {8'h6B, 8'h6C} |-> unsup || (mode == 8'h00
            && dummy inside {8'h00, 8'h08})) else $error("quad out counts wrong");
    quad_io_a:
        assert property (ack && op inside {8'hEB, 8'hEC} |-> unsup || (mode == 8'h02
            && dummy inside {8'h01, 8'h04, 8'h05})) else $error("quad io counts wrong");
    other_unsup_a:
        assert property (ack && !known |-> unsup) else $error("unknown read accepted");
    go_legal_a:
        assert property (go |-> $past(ack) && mode != 8'hFF && dummy != 8'hFF)
        else $error("go for unsupported read");
    first_data_a:
        assert property (data_first |-> run_r && cnt_r == want)
        else $error("first data at wrong cycle");
    late_data_a:
        assert property (run_r |-> cnt_r <= want) else $error("first data late");
endmodule : rls_monitor

/* File: verif/test_sdr_read_latency_select.sv */
`timescale 1ns/1ps
`include "rls_consts.svh"

module test_sdr_read_latency_select;
    import rls_pkg::*;

    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic cfg_we = 1'b0;
    logic [1:0] cfg_code = 2'h3;
    logic cfg_hi = 1'b0;
    logic [6:0] tbl_index = 7'h00;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_op = 8'h00;
    logic [7:0] tbl_data;
    logic [1:0] cur_code;
    logic busy, illegal, ill2, cmd_ready, mode_ph, dummy_ph, done, fail, reject;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h00000047;
    logic [1:0] bcode [5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h2};
    logic [7:0] frq [5] = '{8'h32, 8'h50, 8'h5A, 8'h68, 8'h85};
    logic [7:0] hdr [14] = '{8'h46, 8'h43, 8'h03, 8'h13, 8'h0B, 8'h0C, 8'hFF, 8'hFF,
        8'h6B, 8'h6C, 8'hFF, 8'hFF, 8'hEB, 8'hEC};
    logic [7:0] ops [9] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h6B, 8'h6C, 8'hEB, 8'hEC, 8'h3B};

    rls_link_if lnk ();
    rls_link_if lnk2 ();

    rls_dev rls_dev_inst (.CLK(CLK), .RST_N(RST_N), .LNK(lnk.dev), .CFG_WE(cfg_we),
        .CFG_CODE(cfg_code), .CFG_HI_BAND(cfg_hi), .TBL_INDEX(tbl_index),
        .TBL_DATA(tbl_data), .CUR_CODE(cur_code), .BUSY(busy), .ILLEGAL(illegal));
    rls_dev rls_dev_inst_b (.CLK(CLK), .RST_N(RST_N), .LNK(lnk2.dev), .CFG_WE(cfg_we),
        .CFG_CODE(cfg_code), .CFG_HI_BAND(cfg_hi), .TBL_INDEX(tbl_index),
        .TBL_DATA(), .CUR_CODE(), .BUSY(), .ILLEGAL(ill2));
    rls_host rls_host_inst (.CLK(CLK), .RST_N(RST_N), .LNK(lnk.host), .CMD_VALID(cmd_valid),
        .CMD_OP(cmd_op), .CMD_READY(cmd_ready), .MODE_PH(mode_ph), .DUMMY_PH(dummy_ph),
        .DONE(done), .FAIL(fail), .REJECT(reject));
    rls_monitor rls_monitor_inst (.CLK(CLK), .RST_N(RST_N), .req(lnk.req), .op(lnk.op),
        .go(lnk.go), .ack(lnk.ack), .mode(lnk.mode), .dummy(lnk.dummy),
        .data_first(lnk.data_first));

    // ----------------------------------------------------------------
    // clock, watchdog, model
    // ----------------------------------------------------------------
    always #5 CLK = ~CLK;

    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            complete_run();
        end
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // band 0..4 by rising clock limit, group in table column order
    function automatic logic [15:0] lat(input int b, input int g);
        case (g)
            0: return (b == 0) ? 16'h0000 : 16'hFFFF;
            1: return (b == 0) ? 16'h0000 : 16'h0008;
            3: return (b == 0) ? 16'h0000 : (b == 4) ? 16'hFFFF : 16'h0008;
            5: return (b == 0) ? 16'h0201 : (b == 4) ? 16'hFFFF : (b == 3) ? 16'h0205 : 16'h0204;
            default: return 16'hFFFF;
        endcase
    endfunction : lat

    function automatic int grp(input logic [7:0] op);
        case (op)
            8'h03, 8'h13: return 0;
            8'h0B, 8'h0C: return 1;
            8'h6B, 8'h6C: return 3;
            8'hEB, 8'hEC: return 5;
            default: return 2;
        endcase
    endfunction : grp

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic set_band(input int b);
        @(posedge CLK);
        cfg_we <= 1'b1;
        cfg_code <= bcode[b];
        cfg_hi <= (b == 4);
        @(posedge CLK);
        cfg_we <= 1'b0;
        #1 chk("cur_code", 16'(bcode[b]), 16'(cur_code));
    endtask : set_band

    task automatic run_cmd(input int b, input logic [7:0] op);
        logic [15:0] exp;
        logic [15:0] seen;
        int n, nm, nd, nb, nx;
        exp = lat(b, grp(op));
        seen = 'x;
        n = 0;
        nm = 0;
        nd = 0;
        nb = 0;
        nx = 0;
        do begin
            @(posedge CLK);
            #1;
        end while (cmd_ready !== 1'b1);
        @(posedge CLK);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        @(posedge CLK);
        cmd_valid <= 1'b0;
        // k counts edges after the one that takes the command
        for (int k = 0; k <= 40 && n == 0; k++) begin
            #1;
            if (lnk.ack === 1'b1) seen = {lnk.mode, lnk.dummy};
            nm += (mode_ph === 1'b1);
            nd += (dummy_ph === 1'b1);
            nb += (busy === 1'b1);
            nx += (illegal === 1'b1);
            nx += (fail === 1'b1);
            if (done === 1'b1 || fail === 1'b1 || reject === 1'b1) n = k;
            else @(posedge CLK);
        end
        chk("link_counts", exp, seen);
        chk("illegal_fail", 16'h0000, 16'(nx));
        if (exp[15:8] == 8'hFF) begin
            chk("reject_delay", 16'h0002, 16'(n));
            chk("reject_flag", 16'h0001, 16'(reject));
        end else begin
            chk("done_delay", 16'(4 + exp[15:8] + exp[7:0]), 16'(n));
            chk("done_flag", 16'h0001, 16'(done));
            chk("mode_cycles", 16'(exp[15:8]), 16'(nm));
            chk("dummy_cycles", 16'(exp[7:0]), 16'(nd));
            chk("busy_cycles", 16'(exp[15:8]) + 16'(exp[7:0]), 16'(nb));
        end
    endtask : run_cmd

    task automatic chk_table();
        logic [15:0] e;
        int r, c;
        for (int i = 0; i <= 84; i++) begin
            r = i / 14;
            c = i % 14;
            if (i == 84) e = 16'h0000;
            else if (r == 0) e = 16'(hdr[c]);
            else if (c == 0) e = 16'(frq[r - 1]);
            else if (c == 1) e = 16'(bcode[r - 1]);
            else e = lat(r - 1, (c - 2) / 2);
            if (c >= 2 && r > 0 && i < 84) e = (c % 2 == 0) ? e >> 8 : e & 16'h00FF;
            @(posedge CLK);
            tbl_index <= 7'(i);
            @(posedge CLK);
            #1 chk("table_byte", e, 16'(tbl_data));
        end
    endtask : chk_table

    // far end breaking the rules on the second link
    task automatic bad_go(input int b, input logic [7:0] op);
        int hit;
        set_band(b);
        @(posedge CLK);
        lnk2.req <= 1'b1;
        lnk2.op <= op;
        @(posedge CLK);
        lnk2.req <= 1'b0;
        @(posedge CLK);
        lnk2.go <= 1'b1;
        @(posedge CLK);
        lnk2.go <= 1'b0;
        hit = 0;
        for (int k = 0; k < 12; k++) begin
            #1;
            hit += (ill2 === 1'b1);
            hit += 100 * (lnk2.data_first === 1'b1);
            @(posedge CLK);
        end
        chk("refused_read", 16'h0001, 16'(hit));
    endtask : bad_go

    initial begin
        int b;
        logic [7:0] op;
        lnk2.req = 1'b0;
        lnk2.op = 8'h00;
        lnk2.go = 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        #1 chk("ready_reset", 16'h0001, 16'(cmd_ready));
        chk("code_reset", 16'h0003, 16'(cur_code));
        chk_table();
        for (int i = 0; i < 80; i++) begin
            if (i < 45) begin
                b = i / 9;
                op = ops[i % 9];
            end else begin
                rng = xorshift(rng);
                b = rng % 5;
                op = ops[(rng >> 8) % 9];
            end
            if (i % 9 == 0 || i >= 45) set_band(b);
            run_cmd(b, op);
        end
        bad_go(1, 8'h03);
        bad_go(4, 8'h6B);
        complete_run();
    end
endmodule : test_sdr_read_latency_select
